// ---- src/pwx_pkg.sv ----
// Shared constants and types for the pulse-width exposure trigger controller.
package pwx_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int NS_PER_US     = 1000;
	localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
	localparam int START_DLY_NS  = 380;
	localparam int START_DLY_CYC = (START_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_MIN_US  = 10;

	// ------------------------------------------------------------
	// Minimum trigger cycle terms, kept in half reference ticks
	// ------------------------------------------------------------
	localparam int MULT_HALF_TICKS = 641;
	localparam int MULT_ONE        = 641;
	localparam int MULT_TWO        = 1282;
	localparam int OFFSET_TICKS    = 12205;
	localparam int REF_FAST_MHZ    = 40;
	localparam int REF_SLOW_MHZ    = 20;
	localparam int TICK_SCALE      = 2;
	localparam int OFFSET_HALF     = OFFSET_TICKS * TICK_SCALE;
	localparam int DEN_FAST        = REF_FAST_MHZ * TICK_SCALE;
	localparam int DEN_SLOW        = REF_SLOW_MHZ * TICK_SCALE;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int US_W     = 32;
	localparam int HEIGHT_W = 13;
	localparam int START_W  = 8;
	localparam int TICK_W   = 8;
	localparam int LINE_W   = 16;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		fast_dual_lane_cfg,
		fast_single_lane_cfg,
		slow_dual_lane_cfg,
		slow_single_lane_cfg
	} pwx_link_t;

	typedef enum logic [1:0] {
		exp_idle,
		exp_start,
		exp_run
	} pwx_exp_t;

	typedef struct packed {
		logic                pwc_en;
		logic                overlap_readout;
		pwx_link_t           link;
		logic                vbin_on;
		logic [HEIGHT_W-1:0] height;
	} pwx_cfg_t;

	typedef struct packed {
		logic            exposure_active;
		logic            frame_valid_window;
		logic [US_W-1:0] pulse_width_exposure;
		logic [US_W-1:0] min_cycle_us;
	} pwx_status_t;

endpackage : pwx_pkg

// ---- src/pwx_trig_ctrl.sv ----
// Trigger acceptance and pulse-width exposure control with readout overlap.
`timescale 1ns/1ps
`default_nettype none

module pwx_trig_ctrl
	import pwx_pkg::*;
#(
	parameter int LINE_NS = 4000
) (
	input  wire logic      sys_clk,
	input  wire logic      srst,
	input  wire logic      trig_in,
	input  wire pwx_cfg_t  cfg,
	output logic           trigger_wait,
	output pwx_status_t    status
);

	localparam int LINE_CYC = LINE_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		pwx_exp_t           st;
		logic               sync1;
		logic               sync2;
		logic               trig_prev;
		logic [START_W-1:0] start_cnt;
		logic [TICK_W-1:0]  us_cnt;
		logic [LINE_W-1:0]  line_cnt;
		logic [US_W-1:0]    width_us;
		logic [US_W-1:0]    rd_len;
		logic [US_W-1:0]    rd_cnt;
		logic [US_W-1:0]    since_us;
		logic [US_W-1:0]    min_cyc;
		logic               rd_run;
		logic               rd_pend;
		logic               exp_act;
		logic               div_go;
		logic [US_W-1:0]    num;
		logic [US_W-1:0]    den;
	} pwx_core_t;

	localparam pwx_core_t CORE_RST = '{st: exp_idle, default: '0};

	pwx_core_t       q;
	pwx_core_t       d;
	logic            us_tick;
	logic            line_tick;
	logic            rise;
	logic            mask_ok;
	logic            idle_free;
	logic            accept;
	logic            div_done;
	logic [US_W-1:0] div_quo;
	logic [US_W-1:0] mult;
	logic [US_W-1:0] den_sel;

	pwx_udiv #(
		.W (US_W)
	) u_div (
		.sys_clk (sys_clk),
		.srst    (srst),
		.start   (q.div_go),
		.num     (q.num),
		.den     (q.den),
		.done    (div_done),
		.quo     (div_quo)
	);

	// ------------------------------------------------------------
	// Per-line multiplier and reference divisor for the link setting
	// ------------------------------------------------------------
	// The 320.5 term is carried doubled so the arithmetic stays integer.
	always_comb begin
		mult    = US_W'(MULT_HALF_TICKS);
		den_sel = US_W'(DEN_FAST);
		case (cfg.link)
			fast_dual_lane_cfg: begin
				mult = cfg.vbin_on ? US_W'(MULT_ONE * TICK_SCALE)
				                   : US_W'(MULT_HALF_TICKS);
			end
			fast_single_lane_cfg, slow_dual_lane_cfg: begin
				mult = cfg.vbin_on ? US_W'(MULT_TWO * TICK_SCALE)
				                   : US_W'(MULT_ONE * TICK_SCALE);
			end
			slow_single_lane_cfg: begin
				mult    = cfg.vbin_on ? US_W'(MULT_TWO * TICK_SCALE)
				                      : US_W'(MULT_ONE * TICK_SCALE);
				den_sel = US_W'(DEN_SLOW);
			end
			default: begin
				mult = US_W'(MULT_HALF_TICKS);
			end
		endcase
	end

	// ------------------------------------------------------------
	// Acceptance
	// ------------------------------------------------------------
	// One free-running microsecond tick times the exposure end, and the start too unless overlap moves it to the line tick, so each jitters by under its tick.
	assign us_tick   = q.us_cnt == TICK_W'(CYC_PER_US - 1);
	assign line_tick = q.line_cnt == LINE_W'(LINE_CYC - 1);
	assign rise      = q.sync2 & ~q.trig_prev;
	assign mask_ok   = q.since_us >= q.min_cyc;
	assign idle_free = cfg.pwc_en & (q.st == exp_idle) & ~q.rd_pend;
	// Overlap lets the wait rise while the previous frame still reads out.
	assign trigger_wait = cfg.overlap_readout ? idle_free
	                    : idle_free & ~q.rd_run & mask_ok;
	// A trigger seen while wait is low is dropped on the spot, never held.
	assign accept = rise & trigger_wait;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d           = q;
		d.div_go    = 1'b0;
		d.sync1     = trig_in;
		d.sync2     = q.sync1;
		d.trig_prev = q.sync2;
		d.us_cnt    = us_tick ? '0 : q.us_cnt + TICK_W'(1);
		d.line_cnt  = line_tick ? '0 : q.line_cnt + LINE_W'(1);

		if (us_tick && q.since_us != '1) begin
			d.since_us = q.since_us + US_W'(1);
		end
		if (div_done) begin
			d.rd_len = div_quo;
		end

		// Readout window of the previous exposure.
		if (q.rd_run && us_tick) begin
			if (q.rd_cnt <= US_W'(1)) begin
				d.rd_run = 1'b0;
			end else begin
				d.rd_cnt = q.rd_cnt - US_W'(1);
			end
		end
		if (q.rd_pend && !q.rd_run) begin
			d.rd_run  = 1'b1;
			d.rd_pend = 1'b0;
			d.rd_cnt  = q.rd_len;
			d.min_cyc = q.rd_len + q.width_us;
		end

		case (q.st)
			exp_idle: begin
				if (accept) begin
					d.st        = exp_start;
					d.start_cnt = START_W'(START_DLY_CYC);
					d.since_us  = '0;
					d.width_us  = '0;
					d.div_go    = 1'b1;
					d.num       = (US_W'(cfg.height) + US_W'(1)) * mult
					            + US_W'(OFFSET_HALF);
					d.den       = den_sel;
				end
			end
			exp_start: begin
				if (q.start_cnt != '0) begin
					d.start_cnt = q.start_cnt - START_W'(1);
				end else if (cfg.overlap_readout ? line_tick : us_tick) begin
					d.st      = exp_run;
					d.exp_act = 1'b1;
				end
			end
			exp_run: begin
				if (us_tick) begin
					d.width_us = q.width_us + US_W'(1);
					if (!q.sync2) begin
						d.st      = exp_idle;
						d.exp_act = 1'b0;
						d.rd_pend = 1'b1;
					end
				end
			end
			default: begin
				d.st      = exp_idle;
				d.exp_act = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	assign status.exposure_active      = q.exp_act;
	assign status.frame_valid_window   = q.rd_run;
	assign status.pulse_width_exposure = q.width_us;
	assign status.min_cycle_us         = q.min_cyc;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// ------------------------------------------------------------
	// Assertion helpers
	// ------------------------------------------------------------
	// Kept apart from the core state so that synthesis drops them as a whole.
	typedef struct packed {
		logic [US_W-1:0] num;
		logic [US_W-1:0] den;
		logic [US_W-1:0] rd_ticks;
		logic [US_W-1:0] rd_load;
	} pwx_chk_t;

	pwx_chk_t chk_q;
	pwx_chk_t chk_d;

	// The readout window is counted here independently of the countdown in the core.
	always_comb begin
		chk_d = chk_q;
		if (q.div_go) begin
			chk_d.num = q.num;
			chk_d.den = q.den;
		end
		if (!q.rd_run) begin
			chk_d.rd_ticks = '0;
		end else if (us_tick) begin
			chk_d.rd_ticks = chk_q.rd_ticks + US_W'(1);
		end
		if (q.rd_pend && !q.rd_run) begin
			chk_d.rd_load = q.rd_len;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			chk_q <= '0;
		end else begin
			chk_q <= chk_d;
		end
	end

	idle_holds_a: assert property (q.st == exp_idle && !accept |=> q.st == exp_idle)
		else $error("Exposure left idle without an accepted trigger.");
	wait_readout_a: assert property (!cfg.overlap_readout && q.rd_run |-> !trigger_wait)
		else $error("Trigger wait high during readout with overlap off.");
	wait_overlap_a: assert property (cfg.overlap_readout && q.rd_run && idle_free |-> trigger_wait)
		else $error("Trigger wait low during readout window with overlap on.");
	wait_drop_a: assert property (accept |=> q.st == exp_start && !trigger_wait)
		else $error("Trigger wait still high after a trigger was taken.");
	expo_hold_a: assert property (q.st == exp_run && q.sync2 |=> q.exp_act)
		else $error("Exposure ended while the trigger was still high.");
	start_delay_a: assert property (accept |=> !q.exp_act [*8])
		else $error("Exposure started before the fixed start delay.");
	start_line_a: assert property (accept && cfg.overlap_readout |-> ##[40:600] q.exp_act)
		else $error("Overlap exposure start exceeded delay plus one line.");
	mask_block_a: assert property (!cfg.overlap_readout && q.since_us < q.min_cyc
		|-> !trigger_wait)
		else $error("Trigger wait high inside the minimum trigger cycle.");
	cycle_floor_a: assert property (div_done |-> div_quo * chk_q.den <= chk_q.num
		&& chk_q.num < div_quo * chk_q.den + chk_q.den)
		else $error("Readout length is not the rounded-down microsecond count.");
	expo_end_a: assert property (q.exp_act && !q.sync2 && us_tick |=> !q.exp_act)
		else $error("Exposure outlived the trigger pulse by more than one tick.");
	start_tick_a: assert property (q.st == exp_start && q.start_cnt == '0
		&& !cfg.overlap_readout && us_tick |=> q.exp_act)
		else $error("Exposure start missed its resynchronising tick.");
	start_edge_a: assert property (q.st == exp_start && q.start_cnt == '0
		&& cfg.overlap_readout && line_tick |=> q.exp_act)
		else $error("Overlap exposure start missed its line tick.");
	wait_frame_a: assert property (!cfg.overlap_readout && (q.st != exp_idle || q.rd_pend)
		|-> !trigger_wait)
		else $error("Trigger wait high between accept and readout end.");
	wait_hold_a: assert property (cfg.overlap_readout && q.st != exp_idle |-> !trigger_wait)
		else $error("Trigger wait high while an overlap exposure is under way.");
	readout_len_a: assert property ($fell(q.rd_run) |-> chk_q.rd_ticks == chk_q.rd_load)
		else $error("Readout window length differs from the loaded count.");

	accept_idle_c: cover property (accept && !cfg.overlap_readout);
	accept_overlap_c: cover property (accept && q.rd_run);
	mask_drop_c: cover property (rise && !trigger_wait && !cfg.overlap_readout);
	readout_end_c: cover property ($fell(q.rd_run));
	slow_link_c: cover property (accept && cfg.link == slow_single_lane_cfg);

endmodule : pwx_trig_ctrl

`default_nettype wire

// ---- src/pwx_udiv.sv ----
// Sequential restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none

module pwx_udiv #(
	parameter int W = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         start,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	output logic              done,
	output logic [W-1:0]      quo
);

	localparam int CNT_W = $clog2(W) + 1;

	typedef struct packed {
		logic             busy;
		logic             done;
		logic [CNT_W-1:0] cnt;
		logic [W:0]       rem;
		logic [W-1:0]     qr;
		logic [W-1:0]     den;
	} pwx_div_st_t;

	pwx_div_st_t q;
	pwx_div_st_t d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [W:0] trial;
		trial  = '0;
		d      = q;
		d.done = 1'b0;
		if (start) begin
			d.busy = 1'b1;
			d.cnt  = CNT_W'(W);
			d.rem  = '0;
			d.qr   = num;
			d.den  = den;
		end else if (q.busy) begin
			trial = {q.rem[W-1:0], q.qr[W-1]};
			if (trial >= {1'b0, q.den}) begin
				d.rem = trial - {1'b0, q.den};
				d.qr  = {q.qr[W-2:0], 1'b1};
			end else begin
				d.rem = trial;
				d.qr  = {q.qr[W-2:0], 1'b0};
			end
			d.cnt = q.cnt - CNT_W'(1);
			if (q.cnt == CNT_W'(1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign quo  = q.qr;

endmodule : pwx_udiv

`default_nettype wire

// ---- test/pwx_trig_src.sv ----
// Behavioural external trigger source that sends one pulse per request.
`timescale 1ns/1ps
`default_nettype none

module pwx_trig_src
	import pwx_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       fire,
	input  wire logic [7:0] width_us,
	output logic            trig_in
);
	int cnt_q;

	// Short requests are stretched, since a real source may never send them.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_q   <= 0;
			trig_in <= 1'b0;
		end else if (fire) begin
			cnt_q   <= ((width_us < PULSE_MIN_US) ? PULSE_MIN_US : width_us) * CYC_PER_US;
			trig_in <= 1'b1;
		end else if (cnt_q > 1) begin
			cnt_q <= cnt_q - 1;
		end else begin
			cnt_q   <= 0;
			trig_in <= 1'b0;
		end
	end

endmodule : pwx_trig_src
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking testbench for the pulse-width exposure trigger controller.
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import pwx_pkg::*;
;
	localparam int LINE_NS  = 400;
	localparam int LINE_CYC = LINE_NS / CLK_PERIOD_NS;
	localparam int HGT      = 255;

	logic        sys_clk     = 1'b0;
	logic        srst        = 1'b1;
	logic        fire        = 1'b0;
	logic [7:0]  width_us    = 8'h0A;
	logic        trig_in;
	logic        trigger_wait;
	pwx_cfg_t    cfg         = '0;
	pwx_status_t status;
	int          n_errors    = 0;
	int          check_count = 0;
	int          cyc         = 0;

	pwx_trig_ctrl #(.LINE_NS(LINE_NS)) pwx_trig_ctrl_inst (
		.sys_clk     (sys_clk),
		.srst        (srst),
		.trig_in     (trig_in),
		.cfg         (cfg),
		.trigger_wait(trigger_wait),
		.status      (status)
	);

	pwx_trig_src pwx_trig_src_inst (
		.sys_clk (sys_clk),
		.srst    (srst),
		.fire    (fire),
		.width_us(width_us),
		.trig_in (trig_in)
	);

	always #4 sys_clk = ~sys_clk;

	// ------------------------------------------------------------
	// Shared checks
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// A stuck run is cut short well after the expected span of about 49k cycles.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 75000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
			input logic [31:0] got);
		check_count++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk

	function automatic logic pick(input int k);
		case (k)
			0: return trigger_wait;
			1: return status.exposure_active;
			default: return status.frame_valid_window;
		endcase
	endfunction : pick

	task automatic wait_lvl(input int k, input logic v, input int lim, output int n);
		n = 0;
		while (pick(k) !== v && n <= lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk($sformatf("wait on signal %0d", k), 0, lim, n);
	endtask : wait_lvl

	task automatic hold_lvl(input string nm, input int k, input logic v, input int lim);
		repeat (lim) begin
			@(posedge sys_clk);
			#1;
			chk(nm, v, v, pick(k));
		end
	endtask : hold_lvl

	task automatic pulse(input logic [7:0] w);
		@(posedge sys_clk);
		width_us <= w;
		fire     <= 1'b1;
		@(posedge sys_clk);
		fire <= 1'b0;
		#1;
	endtask : pulse

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idle();
		@(posedge sys_clk);
		#1;
		chk("wait while disabled", 0, 0, trigger_wait);
		@(posedge sys_clk);
		cfg.pwc_en <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk("wait at idle", 1, 1, trigger_wait);
	endtask : t_idle

	// Fast dual lane, no binning, height 0: readout is (641 + 24410) / 80 us.
	task automatic t_no_overlap();
		int n;
		pulse(8'h0C);
		wait_lvl(0, 1'b0, 8, n);
		wait_lvl(1, 1'b1, START_DLY_CYC + CYC_PER_US + 4, n);
		wait_lvl(1, 1'b0, 14 * CYC_PER_US, n);
		chk("exposure cycles", 10 * CYC_PER_US, 13 * CYC_PER_US, n);
		wait_lvl(2, 1'b1, 8, n);
		repeat (4) @(posedge sys_clk);
		#1;
		chk("wait in readout", 0, 0, trigger_wait);
		chk("width count", 10, 13, status.pulse_width_exposure);
		chk("min cycle", 25051 / 80 + 10, 25051 / 80 + 13, status.min_cycle_us);
		pulse(8'h0A);
		hold_lvl("stray exposure", 1, 1'b0, 12 * CYC_PER_US);
		wait_lvl(2, 1'b0, 320 * CYC_PER_US, n);
		hold_lvl("queued exposure", 1, 1'b0, 300);
	endtask : t_no_overlap

	// Mid-rate binned, height 0: readout is (2564 + 24410) / 80 us.
	task automatic t_overlap();
		int n;
		@(posedge sys_clk);
		cfg.overlap_readout <= 1'b1;
		cfg.link            <= slow_dual_lane_cfg;
		cfg.vbin_on         <= 1'b1;
		wait_lvl(0, 1'b1, 20 * CYC_PER_US, n);
		pulse(8'h0A);
		wait_lvl(0, 1'b0, 8, n);
		wait_lvl(2, 1'b1, 16 * CYC_PER_US, n);
		repeat (4) @(posedge sys_clk);
		#1;
		chk("wait in prior readout", 1, 1, trigger_wait);
		chk("min cycle binned", 26974 / 80 + 8, 26974 / 80 + 11, status.min_cycle_us);
		pulse(8'h0A);
		wait_lvl(0, 1'b0, 8, n);
		wait_lvl(1, 1'b1, START_DLY_CYC + LINE_CYC + 6, n);
		chk("readout during exposure", 1, 1, status.frame_valid_window);
		wait_lvl(1, 1'b0, 12 * CYC_PER_US, n);
		chk("overlap exposure", 8 * CYC_PER_US, 11 * CYC_PER_US, n);
	endtask : t_overlap

	// A mid-run reset ends the long readout, so each link setting starts from idle.
	task automatic t_link(input pwx_link_t lk, input logic vb, input int m, input int dn);
		int n;
		int e;
		e = ((HGT + 1) * m + OFFSET_HALF) / dn;
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst                <= 1'b0;
		cfg.overlap_readout <= 1'b0;
		cfg.link            <= lk;
		cfg.vbin_on         <= vb;
		cfg.height          <= HEIGHT_W'(HGT);
		@(posedge sys_clk);
		#1;
		chk("wait after reset", 1, 1, trigger_wait);
		chk("exposure after reset", 0, 0, status.exposure_active);
		chk("readout after reset", 0, 0, status.frame_valid_window);
		pulse(8'h0A);
		wait_lvl(2, 1'b1, 15 * CYC_PER_US, n);
		chk("min cycle per link", e + 10, e + 13, status.min_cycle_us);
	endtask : t_link

	initial begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		t_idle();
		t_no_overlap();
		t_overlap();
		t_link(fast_dual_lane_cfg, 1'b1, MULT_ONE * TICK_SCALE, DEN_FAST);
		t_link(fast_single_lane_cfg, 1'b0, MULT_ONE * TICK_SCALE, DEN_FAST);
		t_link(slow_single_lane_cfg, 1'b0, MULT_ONE * TICK_SCALE, DEN_SLOW);
		t_link(slow_single_lane_cfg, 1'b1, MULT_TWO * TICK_SCALE, DEN_SLOW);
		tally_and_finish();
	end

endmodule : tb_top
`default_nettype wire
